/* bench/analog_front_model.sv */
// behavioural model of the four analog comparator front ends
`timescale 1ns/100ps
`default_nettype none
module analog_front_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // analog levels, one byte per channel
  input wire logic [31:0] vin_plus,
  input wire logic [31:0] vin_minus,
  input wire logic slow,
  // raw compare results
  output logic [3:0] cmp_raw
);
  logic [3:0] now_cmp;
  logic [3:0] d1_reg;
  logic [3:0] d2_reg;
  // raw result is one only while plus is above minus
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      now_cmp[i] = vin_plus[8*i+:8] > vin_minus[8*i+:8];
  end
  // settling lag of one or two cycles
  always_ff @(posedge clk)
  begin
    d1_reg <= rstn ? now_cmp : 4'h0;
    d2_reg <= rstn ? d1_reg : 4'h0;
  end
  assign cmp_raw = slow ? d2_reg : d1_reg;
endmodule : analog_front_model
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the comparator status aggregator
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t %s got %0h exp %0h", $time, m, g, e); end end
module tb;
  logic clk, rstn, device_idle, comparators_halted, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, vin_plus, vin_minus, rd;
  logic [3:0] s_axi_wstrb, cmp_raw, event_trigger, inv, want;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int err_total, checked, cycles, n;
  int tcnt [4];
  // ************
  // instances
  // ************
  comparator_status_aggregator dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cmp_raw(cmp_raw), .device_idle(device_idle),
    .event_trigger(event_trigger), .comparators_halted(comparators_halted));
  analog_front_model front (.clk(clk), .rstn(rstn), .vin_plus(vin_plus),
    .vin_minus(vin_minus), .slow(slow), .cmp_raw(cmp_raw));
  // clock, trigger pulse counters and hang guard
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
      if (event_trigger[i] === 1'b1) tcnt[i] <= tcnt[i] + 1;
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  // ************
  // helpers
  // ************
  function automatic logic [31:0] ctl(logic en, logic iv, logic amp, logic [1:0] e);
    return {16'h0, en, 1'b0, iv, 2'h0, amp, 2'h0, e, 6'h0};
  endfunction : ctl
  function automatic logic [31:0] stat(logic h, logic [3:0] ev, logic [3:0] r);
    return {16'h0, h, 3'h0, ev, 4'h0, r};
  endfunction : stat
  function automatic logic [7:0] ca(int c);
    return comparator_status_pkg::CHAN_BASE + comparator_status_pkg::CHAN_STRIDE * 8'(c);
  endfunction : ca
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd_reg
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    `CHK({resp, rd}, {comparator_status_pkg::RESP_OKAY, e}, "read")
  endtask : chk_rd
  // random analog levels that give the wanted raw results
  task automatic lv(input logic [3:0] w);
    logic [7:0] b;
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($urandom_range(1, 254));
      vin_minus[8*i+:8] <= b;
      vin_plus[8*i+:8] <= w[i] ? b + 8'h1 : b - 8'h1;
    end
    slow <= 1'($urandom_range(0, 1));
    repeat (6) @(posedge clk);
  endtask : lv
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // ************
  // tests
  // ************
  initial
  begin
    {rstn, device_idle, slow, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, vin_plus, vin_minus} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    void'($urandom(32'h57a3));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk_rd(comparator_status_pkg::STATUS_OFFSET, 32'h0);
    for (int c = 0; c < 4; c++) chk_rd(ca(c), 32'h0);
    $display("test reset done");
    wr(8'h40, 32'hffff, 4'hf);
    `CHK(resp, comparator_status_pkg::RESP_SLVERR, "bresp")
    rd_reg(8'h40);
    `CHK({resp, rd}, {comparator_status_pkg::RESP_SLVERR, 32'h0}, "rresp")
    wr(8'h00, 32'hffffffff, 4'hf);
    chk_rd(8'h00, stat(1, 0, 0));
    wr(8'h00, 32'h0, 4'h1);
    chk_rd(8'h00, stat(1, 0, 0));
    wr(8'h00, 32'h0, 4'h2);
    chk_rd(8'h00, stat(0, 0, 0));
    $display("test bits done");
    repeat (6)
    begin
      inv = 4'($urandom);
      want = 4'($urandom);
      for (int c = 0; c < 4; c++) wr(ca(c), ctl(1, inv[c], 0, 2'h0), 4'h3);
      lv(want);
      chk_rd(8'h00, stat(0, 0, want ^ inv));
    end
    $display("test results done");
    for (int c = 0; c < 4; c++) wr(ca(c), ctl(1, 0, 0, 2'h0), 4'h3);
    lv(4'h0);
    for (int c = 0; c < 4; c++)
      for (int e = 0; e < 4; e++)
      begin
        wr(ca(c), ctl(1, 0, 0, 2'(e)), 4'h3);
        n = tcnt[c];
        lv(4'h1 << c);
        chk_rd(8'h00, stat(0, e[0] ? 4'h1 << c : 4'h0, 4'h1 << c));
        lv(4'h0);
        chk_rd(8'h00, stat(0, e != 0 ? 4'h1 << c : 4'h0, 4'h0));
        `CHK(tcnt[c] - n, int'(e != 0), "triggers")
        wr(ca(c), ctl(1, 0, 0, 2'h0), 4'h3);
        chk_rd(8'h00, 32'h0);
      end
    $display("test events done");
    for (int c = 0; c < 4; c++)
    begin
      wr(ca(c), ctl(1, 0, 1, 2'h0), 4'h3);
      rd_reg(ca(c));
      `CHK(rd[10], 1'(c < 3), "amp")
    end
    lv(4'hf);
    chk_rd(8'h00, stat(0, 0, 4'h8));
    for (int c = 0; c < 4; c++) wr(ca(c), ctl(1, 0, 0, 2'h0), 4'h3);
    lv(4'h0);
    $display("test amplifier done");
    wr(8'h00, 32'h8000, 4'h2);
    device_idle <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(comparators_halted, 1'b1, "halted")
    lv(4'hf);
    chk_rd(8'h00, stat(1, 0, 0));
    device_idle <= 1'b0;
    lv(4'hf);
    chk_rd(8'h00, stat(1, 0, 4'hf));
    wr(8'h00, 32'h0, 4'h3);
    device_idle <= 1'b1;
    lv(4'h0);
    `CHK(comparators_halted, 1'b0, "running")
    chk_rd(8'h00, 32'h0);
    device_idle <= 1'b0;
    $display("test idle done");
    // reset in mid-run with an event, a result and the halt bit set
    wr(ca(0), ctl(1, 0, 0, 2'h3), 4'h3);
    lv(4'h1);
    chk_rd(8'h00, stat(0, 4'h1, 4'h1));
    wr(8'h00, 32'h8000, 4'h2);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk_rd(8'h00, 32'h0);
    chk_rd(ca(0), 32'h0);
    $display("test reset again done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire

/* src/comparator_channel.sv */
// one comparator channel: polarity, result capture and sticky event flag
`timescale 1ns/100ps
`default_nettype none
module comparator_channel
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // analog side
  input wire logic raw_result,
  // control
  input wire logic run,
  input wire logic invert,
  input wire logic [1:0] edge_sel,
  input wire logic clear_event,
  // status
  output logic result_out,
  output logic event_out,
  output logic trigger_out
);
  logic result_reg, result_next;
  logic event_reg, event_next;
  logic trigger_reg, trigger_next;
  logic adjusted;
  logic hit;

  // next state: polarity, edge match, sticky flag
  always_comb
  begin
    adjusted = raw_result ^ invert;
    case (comparator_status_pkg::edge_sel_t'(edge_sel))
      comparator_status_pkg::EDGE_RISE: hit = adjusted & ~result_reg;
      comparator_status_pkg::EDGE_FALL: hit = ~adjusted & result_reg;
      comparator_status_pkg::EDGE_ANY: hit = adjusted ^ result_reg;
      default: hit = 1'b0;
    endcase
    hit = hit & run;
    result_next = run ? adjusted : result_reg;
    // a new event in the clear cycle keeps the flag set
    event_next = hit | (event_reg & ~clear_event);
    // no trigger while the flag is pending
    trigger_next = hit & ~event_reg;
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      result_reg <= comparator_status_pkg::RESET_BIT;
      event_reg <= comparator_status_pkg::RESET_BIT;
      trigger_reg <= comparator_status_pkg::RESET_BIT;
    end
    else
    begin
      result_reg <= result_next;
      event_reg <= event_next;
      trigger_reg <= trigger_next;
    end
  end

  assign result_out = result_reg;
  assign event_out = event_reg;
  assign trigger_out = trigger_reg;
  // ****************************************
  // assertions
  // ****************************************
  property p_polarity;
    @(posedge clk) disable iff (!rstn)
    run |=> result_reg == ($past(raw_result) ^ $past(invert));
  endproperty
  a_polarity: assert property (p_polarity) else $error("result polarity wrong");
  property p_event_cause;
    @(posedge clk) disable iff (!rstn)
    $rose(event_reg) |-> trigger_reg;
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("event without trigger");
  property p_suppress;
    @(posedge clk) disable iff (!rstn)
    event_reg |=> !trigger_reg;
  endproperty
  a_suppress: assert property (p_suppress) else $error("trigger while flag set");
  property p_edge_off;
    @(posedge clk) disable iff (!rstn)
    edge_sel == comparator_status_pkg::EDGE_OFF |=> !trigger_reg;
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("trigger with events off");
  c_trigger: cover property (@(posedge clk) disable iff (!rstn) trigger_reg);
endmodule : comparator_channel
`default_nettype wire

/* src/comparator_status_aggregator.sv */
// comparator status aggregator with axi4-lite register slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - idle-stop bit halts comparators during idle
// - status bits 11:8 mirror channel events
// - status bits 3:0 mirror channel results
// - result is one when plus exceeds minus
// - event bit one after event, else zero
// - unimplemented bits read zero, ignore writes
// - four channels, amplifier mode on 1-3
// - pending event flag suppresses further triggers
// - edge select: off, rise, fall, any
// - polarity invert flips the result
module comparator_status_aggregator
#(
  parameter int NUM_CHANNELS = 4,
  parameter int AMP_CHANNELS = 3
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // axi4-lite write address and data
  input wire logic [comparator_status_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [comparator_status_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [comparator_status_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [comparator_status_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // comparator side
  input wire logic [NUM_CHANNELS-1:0] cmp_raw,
  input wire logic device_idle,
  output logic [NUM_CHANNELS-1:0] event_trigger,
  output logic comparators_halted
);
  // assertions below share one clock and reset
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // parameter check
  // ****************************************
  if (NUM_CHANNELS < 1 || NUM_CHANNELS > 4 || AMP_CHANNELS > NUM_CHANNELS)
  begin : g_bad_params
    $error("unsupported channel counts");
  end
  // address decode helpers
  function automatic logic is_chan(input logic [comparator_status_pkg::ADDR_W-1:0] a);
    is_chan = (a >= comparator_status_pkg::CHAN_BASE) && (a[1:0] == 2'h0) &&
      ((a - comparator_status_pkg::CHAN_BASE) <
       8'(NUM_CHANNELS * comparator_status_pkg::CHAN_STRIDE));
  endfunction : is_chan
  function automatic logic [1:0] chan_idx(input logic [comparator_status_pkg::ADDR_W-1:0] a);
    logic [comparator_status_pkg::ADDR_W-1:0] d;
    d = a - comparator_status_pkg::CHAN_BASE;
    chan_idx = d[3:2];
  endfunction : chan_idx
  // ****************************************
  // control state
  // ****************************************
  logic halt_reg, halt_next, halted_reg, halted_next;
  logic [NUM_CHANNELS-1:0] enable_reg, enable_next, invert_reg, invert_next;
  logic [NUM_CHANNELS-1:0] amp_reg, amp_next, chan_clear, run, result_vec, event_vec;
  logic [NUM_CHANNELS-1:0][1:0] edge_reg, edge_next;
  // bus state
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [comparator_status_pkg::ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [comparator_status_pkg::DATA_W-1:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic do_write, aw_take, w_take, ar_take;
  logic [comparator_status_pkg::REG_W-1:0] status_word;
  // ****************************************
  // channels
  // ****************************************
  // idle gating applies to every channel at once
  always_comb
  begin
    halted_next = device_idle & halt_reg;
    run = enable_reg & ~amp_reg & {NUM_CHANNELS{~halted_next}};
  end
  for (genvar i = 0; i < NUM_CHANNELS; i++)
  begin : g_chan
    comparator_channel u_chan
    (
      .clk(clk),
      .rstn(rstn),
      .raw_result(cmp_raw[i]),
      .run(run[i]),
      .invert(invert_reg[i]),
      .edge_sel(edge_reg[i]),
      .clear_event(chan_clear[i]),
      .result_out(result_vec[i]),
      .event_out(event_vec[i]),
      .trigger_out(event_trigger[i])
    );
  end
  // ****************************************
  // axi4-lite slave
  // ****************************************
  // handshakes, write commit and read capture
  always_comb
  begin
    aw_take = s_axi_awvalid & awready_reg;
    w_take = s_axi_wvalid & wready_reg;
    ar_take = s_axi_arvalid & arready_reg;
    do_write = aw_have_reg & w_have_reg & ~bvalid_reg;
    aw_have_next = (aw_have_reg & ~do_write) | aw_take;
    w_have_next = (w_have_reg & ~do_write) | w_take;
    aw_addr_next = aw_take ? s_axi_awaddr : aw_addr_reg;
    w_data_next = w_take ? s_axi_wdata : w_data_reg;
    w_strb_next = w_take ? s_axi_wstrb : w_strb_reg;
    awready_next = ~aw_have_next;
    wready_next = ~w_have_next;
    bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
    bresp_next = bresp_reg;
    if (do_write)
      bresp_next = (aw_addr_reg == comparator_status_pkg::STATUS_OFFSET ||
        is_chan(aw_addr_reg)) ? comparator_status_pkg::RESP_OKAY :
        comparator_status_pkg::RESP_SLVERR;
    rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
    arready_next = ~rvalid_next;
    // status word, unused positions stay zero
    status_word = '0;
    status_word[comparator_status_pkg::HALT_BIT] = halt_reg;
    status_word[comparator_status_pkg::EVT_LSB +: NUM_CHANNELS] = event_vec;
    status_word[comparator_status_pkg::OUT_LSB +: NUM_CHANNELS] = result_vec;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take)
    begin
      rdata_next = '0;
      rresp_next = comparator_status_pkg::RESP_OKAY;
      if (s_axi_araddr == comparator_status_pkg::STATUS_OFFSET)
        rdata_next[comparator_status_pkg::REG_W-1:0] = status_word;
      else if (is_chan(s_axi_araddr))
      begin
        rdata_next[comparator_status_pkg::CH_ENABLE_BIT] = enable_reg[chan_idx(s_axi_araddr)];
        rdata_next[comparator_status_pkg::CH_INVERT_BIT] = invert_reg[chan_idx(s_axi_araddr)];
        rdata_next[comparator_status_pkg::CH_AMP_BIT] = amp_reg[chan_idx(s_axi_araddr)];
        rdata_next[comparator_status_pkg::CH_EVENT_BIT] = event_vec[chan_idx(s_axi_araddr)];
        rdata_next[comparator_status_pkg::CH_RESULT_BIT] = result_vec[chan_idx(s_axi_araddr)];
        rdata_next[comparator_status_pkg::CH_EDGE_LSB +: 2] = edge_reg[chan_idx(s_axi_araddr)];
      end
      else
        rresp_next = comparator_status_pkg::RESP_SLVERR;
    end
  end
  // register writes, only implemented bits take effect
  always_comb
  begin
    halt_next = halt_reg;
    enable_next = enable_reg;
    invert_next = invert_reg;
    amp_next = amp_reg;
    edge_next = edge_reg;
    chan_clear = '0;
    if (do_write && aw_addr_reg == comparator_status_pkg::STATUS_OFFSET &&
        w_strb_reg[comparator_status_pkg::LANE_HI])
      halt_next = w_data_reg[comparator_status_pkg::HALT_BIT];
    for (int i = 0; i < NUM_CHANNELS; i++)
    begin
      if (do_write && is_chan(aw_addr_reg) && chan_idx(aw_addr_reg) == 2'(i))
      begin
        if (w_strb_reg[comparator_status_pkg::LANE_HI])
        begin
          enable_next[i] = w_data_reg[comparator_status_pkg::CH_ENABLE_BIT];
          invert_next[i] = w_data_reg[comparator_status_pkg::CH_INVERT_BIT];
          if (i < AMP_CHANNELS)
            amp_next[i] = w_data_reg[comparator_status_pkg::CH_AMP_BIT];
          // writing zero to the event bit clears it
          chan_clear[i] = ~w_data_reg[comparator_status_pkg::CH_EVENT_BIT];
        end
        if (w_strb_reg[comparator_status_pkg::LANE_LO])
          edge_next[i] = w_data_reg[comparator_status_pkg::CH_EDGE_LSB +: 2];
      end
    end
  end
  // all state registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      halt_reg <= comparator_status_pkg::RESET_BIT;
      halted_reg <= comparator_status_pkg::RESET_BIT;
      enable_reg <= '0;
      invert_reg <= '0;
      amp_reg <= '0;
      edge_reg <= {NUM_CHANNELS{comparator_status_pkg::RESET_EDGE}};
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= comparator_status_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= comparator_status_pkg::RESP_OKAY;
      rdata_reg <= '0;
    end
    else
    begin
      halt_reg <= halt_next;
      halted_reg <= halted_next;
      enable_reg <= enable_next;
      invert_reg <= invert_next;
      amp_reg <= amp_next;
      edge_reg <= edge_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end
  // outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign comparators_halted = halted_reg;
  // ****************************************
  // assertions
  // ****************************************
  logic status_rd;
  assign status_rd = ar_take && s_axi_araddr == comparator_status_pkg::STATUS_OFFSET;
  property p_halt_freezes;
    (device_idle && halt_reg) |=> $stable(result_vec);
  endproperty
  a_halt_freezes: assert property (p_halt_freezes) else $error("result moved while halted");
  property p_event_mirror;
    status_rd |=> s_axi_rdata[11:8] == $past(event_vec[3:0]);
  endproperty
  a_event_mirror: assert property (p_event_mirror) else $error("event bits wrong");
  property p_result_mirror;
    status_rd |=> s_axi_rdata[3:0] == $past(result_vec[3:0]);
  endproperty
  a_result_mirror: assert property (p_result_mirror) else $error("result bits wrong");
  property p_reserved_zero;
    status_rd |=> s_axi_rdata[14:12] == 3'h0 && s_axi_rdata[7:4] == 4'h0 &&
      s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
  property p_no_amp_ch4;
    !amp_reg[NUM_CHANNELS-1] || NUM_CHANNELS <= AMP_CHANNELS;
  endproperty
  a_no_amp_ch4: assert property (p_no_amp_ch4) else $error("amp mode on channel 4");
  property p_idle_gate;
    (device_idle && halt_reg) |=> comparators_halted && $past(run) == '0;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("halt not shown");
  c_halted: cover property (comparators_halted);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == comparator_status_pkg::RESP_SLVERR);
endmodule : comparator_status_aggregator
`default_nettype wire

/* src/comparator_status_pkg.sv */
// shared constants for the comparator status block
package comparator_status_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // register byte addresses
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] CHAN_BASE = 8'h04;
  localparam logic [7:0] CHAN_STRIDE = 8'h04;
  // status register fields
  localparam int HALT_BIT = 15;
  localparam int EVT_LSB = 8;
  localparam int OUT_LSB = 0;
  // channel control register fields
  localparam int CH_ENABLE_BIT = 15;
  localparam int CH_INVERT_BIT = 13;
  localparam int CH_AMP_BIT = 10;
  localparam int CH_EVENT_BIT = 9;
  localparam int CH_RESULT_BIT = 8;
  localparam int CH_EDGE_LSB = 6;
  // byte lanes holding the register halves
  localparam int LANE_HI = 1;
  localparam int LANE_LO = 0;
  // reset values
  localparam logic RESET_BIT = 1'h0;
  localparam logic [1:0] RESET_EDGE = 2'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // event edge selection codes
  typedef enum logic [1:0] {
    EDGE_OFF = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_ANY = 2'h3
  } edge_sel_t;
endpackage : comparator_status_pkg
